/* smp_pkg.sv */
package smp_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int unsigned DATA_W  = 16;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned WORD_AW = 11;
  localparam int unsigned DEPTH   = 2048;
  localparam int unsigned SYNC_W  = 41;

  // ***************************************************************
  // Reset values and the frame counter step
  // ***************************************************************
  localparam logic [DATA_W-1:0]  DATA_RST  = 16'h0000;
  localparam logic [WORD_AW-1:0] COUNT_RST = 11'h000;
  localparam logic [WORD_AW-1:0] COUNT_ONE = 11'h001;

  // ***************************************************************
  // Operating modes, chosen from the three mode-select pins
  // ***************************************************************
  typedef enum logic [2:0] {
    SMP_MODE_CONNECT  = 3'b000,
    SMP_MODE_DATA     = 3'b001,
    SMP_MODE_EXTERNAL = 3'b010,
    SMP_MODE_COUNTER  = 3'b011,
    SMP_MODE_SHIFT    = 3'b100
  } smp_mode_e;

  // ***************************************************************
  // Microport handshake states
  // ***************************************************************
  typedef enum logic [1:0] {
    SMP_ST_IDLE  = 2'b00,
    SMP_ST_XFER  = 2'b01,
    SMP_ST_DRIVE = 2'b10,
    SMP_ST_ACK   = 2'b11
  } smp_state_e;

endpackage

/* smp_pin_sync.sv */
`timescale 1ns/1ps

module smp_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  // Pins in, filtered levels out
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_level;

  // A bit only moves once the second and third stages agree
  assign next_level = (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & level_out);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stage1    <= '0;
      stage2    <= '0;
      stage3    <= '0;
      level_out <= '0;
    end else begin
      stage1    <= pin_in;
      stage2    <= stage1;
      stage3    <= stage2;
      level_out <= next_level;
    end
  end

endmodule // smp_pin_sync

/* smp_switch_port.sv */
`timescale 1ns/1ps

module smp_switch_port (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst_b,
  // Mode pins
  input  wire logic                        mode_select_x,
  input  wire logic                        mode_select_y,
  input  wire logic                        mode_select_z,
  // Microport handshake
  input  wire logic                        device_select_n,
  input  wire logic                        data_strobe_n,
  input  wire logic                        read_write,
  output logic                             transfer_ack_n_out,
  output logic                             transfer_ack_n_oe,
  // Input and microport data bus
  input  wire logic [smp_pkg::DATA_W-1:0]  input_data_bus_in,
  output logic      [smp_pkg::DATA_W-1:0]  input_data_bus_out,
  output logic                             input_data_bus_oe,
  // Address and output bus
  input  wire logic [smp_pkg::ADDR_W-1:0]  address_bus,
  input  wire logic                        output_bus_enable,
  input  wire logic                        address_passthrough_select,
  output logic      [smp_pkg::DATA_W-1:0]  output_data_bus,
  output logic                             output_data_bus_oe,
  // Frame timing
  input  wire logic                        frame_pulse_n,
  output logic      [smp_pkg::WORD_AW-1:0] frame_count
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [smp_pkg::SYNC_W-1:0]  pins_raw;
  logic [smp_pkg::SYNC_W-1:0]  pins_f;
  logic [2:0]                  mode_bits;
  logic                        sel_f;
  logic                        strb_f;
  logic                        frm_f;
  logic                        sel_n_f;
  logic                        strb_n_f;
  logic                        rw_f;
  logic                        oen_f;
  logic                        pass_f;
  logic                        frm_n_f;
  logic [smp_pkg::ADDR_W-1:0]  addr_f;
  logic [smp_pkg::DATA_W-1:0]  din_f;

  // Active-low pins pass inverted so a cleared synchroniser reads as idle;
  // otherwise reset release looks like a strobe fall with select low
  assign pins_raw = {mode_select_z, mode_select_y, mode_select_x, ~device_select_n,
                     ~data_strobe_n, read_write, output_bus_enable,
                     address_passthrough_select, ~frame_pulse_n, address_bus,
                     input_data_bus_in};

  smp_pin_sync #(.WIDTH(smp_pkg::SYNC_W)) u_sync (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .pin_in    (pins_raw),
    .level_out (pins_f)
  );

  assign {mode_bits, sel_f, strb_f, rw_f, oen_f, pass_f, frm_f, addr_f, din_f} = pins_f;
  assign sel_n_f  = !sel_f;
  assign strb_n_f = !strb_f;
  assign frm_n_f  = !frm_f;

  // ***************************************************************
  // Mode decode
  // ***************************************************************
  smp_pkg::smp_mode_e mode;
  logic               m_conn;
  logic               m_data;
  logic               m_ext;
  logic               m_cnt;
  logic               m_shift;
  logic               selected;

  assign mode     = smp_pkg::smp_mode_e'(mode_bits);
  assign m_conn   = (mode == smp_pkg::SMP_MODE_CONNECT);
  assign m_data   = (mode == smp_pkg::SMP_MODE_DATA);
  assign m_ext    = (mode == smp_pkg::SMP_MODE_EXTERNAL);
  assign m_cnt    = (mode == smp_pkg::SMP_MODE_COUNTER);
  assign m_shift  = (mode == smp_pkg::SMP_MODE_SHIFT);
  // Counter mode and unused codes never take a microport access
  assign selected = !sel_n_f && (m_conn || m_data || m_ext || m_shift);

  // ***************************************************************
  // Frame counter
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      frame_count <= smp_pkg::COUNT_RST;
    end else if (!frm_n_f && !m_shift) begin
      frame_count <= smp_pkg::COUNT_RST;
    end else begin
      frame_count <= frame_count + smp_pkg::COUNT_ONE;
    end
  end

  // ***************************************************************
  // Microport handshake
  // ***************************************************************
  smp_pkg::smp_state_e              state;
  smp_pkg::smp_state_e              next_state;
  logic                             strb_n_prev;
  logic                             strobe_fall;
  logic                             rw_lat;
  logic                             next_rw_lat;
  logic [smp_pkg::WORD_AW-1:0]      up_addr;
  logic [smp_pkg::DATA_W-1:0]       up_data;
  logic                             end_cycle;

  // Strobe only counts where it has meaning; counter and shift ignore it
  assign strobe_fall = strb_n_prev && !strb_n_f && selected && !m_shift;
  assign end_cycle   = strb_n_f || !selected;
  // Data mode reads regardless of the rw pin
  assign next_rw_lat = m_data ? 1'b1 : rw_f;

  always_comb begin
    next_state = state;
    unique case (state)
      smp_pkg::SMP_ST_IDLE: begin
        if (strobe_fall) begin
          next_state = smp_pkg::SMP_ST_XFER;
        end
      end
      smp_pkg::SMP_ST_XFER: begin
        next_state = rw_lat ? smp_pkg::SMP_ST_DRIVE : smp_pkg::SMP_ST_ACK;
      end
      smp_pkg::SMP_ST_DRIVE: begin
        next_state = smp_pkg::SMP_ST_ACK;
      end
      smp_pkg::SMP_ST_ACK: begin
        if (end_cycle) begin
          next_state = smp_pkg::SMP_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state     <= smp_pkg::SMP_ST_IDLE;
      strb_n_prev <= 1'b1;
      rw_lat    <= 1'b1;
      up_addr   <= smp_pkg::COUNT_RST;
      up_data   <= smp_pkg::DATA_RST;
    end else begin
      state     <= next_state;
      strb_n_prev <= strb_n_f;
      if (strobe_fall) begin
        rw_lat  <= next_rw_lat;
        up_addr <= addr_f[smp_pkg::WORD_AW-1:0];
        up_data <= din_f;
      end
    end
  end

  // ***************************************************************
  // Stream path for counter and external modes
  // ***************************************************************
  // Rw and address are taken one edge, the access made on the next
  logic                        st_rw;
  logic [smp_pkg::WORD_AW-1:0] st_addr;
  logic [smp_pkg::DATA_W-1:0]  st_data;
  logic                        st_active;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_rw     <= 1'b1;
      st_addr   <= smp_pkg::COUNT_RST;
      st_data   <= smp_pkg::DATA_RST;
      st_active <= 1'b0;
    end else begin
      st_rw     <= rw_f;
      st_addr   <= m_ext ? addr_f[smp_pkg::WORD_AW-1:0] : frame_count;
      st_data   <= din_f;
      st_active <= m_ext || m_cnt;
    end
  end

  // ***************************************************************
  // Memory
  // ***************************************************************
  logic [smp_pkg::DATA_W-1:0]  mem [smp_pkg::DEPTH];
  logic                        up_we;
  logic                        st_we;
  logic                        dm_we;
  logic                        mem_we;
  logic [smp_pkg::WORD_AW-1:0] wr_addr;
  logic [smp_pkg::DATA_W-1:0]  wr_data;
  logic [smp_pkg::WORD_AW-1:0] rd_addr;
  logic [smp_pkg::DATA_W-1:0]  mem_rd;

  assign up_we   = (state == smp_pkg::SMP_ST_XFER) && !rw_lat && m_conn;
  assign st_we   = st_active && !st_rw && (m_ext || m_cnt);
  // Data mode stores the incoming stream at the frame count
  assign dm_we   = m_data;
  assign mem_we  = up_we || st_we || dm_we;
  assign wr_addr = up_we ? up_addr : (st_we ? st_addr : frame_count);
  assign wr_data = up_we ? up_data : (st_we ? st_data : din_f);
  // Microport reads win the read port while a transfer is open
  assign rd_addr = (state != smp_pkg::SMP_ST_IDLE) ? up_addr :
                   (st_active ? st_addr : addr_f[smp_pkg::WORD_AW-1:0]);

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[wr_addr] <= wr_data;
    end
    mem_rd <= mem[rd_addr];
  end

  // ***************************************************************
  // Microport data and acknowledge pins
  // ***************************************************************
  logic next_in_oe;
  logic next_ack_oe;

  assign next_in_oe  = m_conn && rw_lat && selected &&
                       ((next_state == smp_pkg::SMP_ST_DRIVE) ||
                        (next_state == smp_pkg::SMP_ST_ACK));
  assign next_ack_oe = (next_state == smp_pkg::SMP_ST_ACK);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      input_data_bus_out <= smp_pkg::DATA_RST;
      input_data_bus_oe  <= 1'b0;
      transfer_ack_n_out <= 1'b0;
      transfer_ack_n_oe  <= 1'b0;
    end else begin
      if (state == smp_pkg::SMP_ST_XFER) begin
        input_data_bus_out <= mem_rd;
      end
      input_data_bus_oe  <= next_in_oe;
      transfer_ack_n_out <= 1'b0;
      transfer_ack_n_oe  <= next_ack_oe;
    end
  end

  // ***************************************************************
  // Output data bus
  // ***************************************************************
  logic                       oen_samp;
  logic                       pass_samp;
  logic [smp_pkg::DATA_W-1:0] addr_hold;
  logic                       sel_block;
  logic                       strb_block;
  logic                       next_out_oe;

  assign sel_block   = sel_n_f && !(m_conn || m_shift);
  assign strb_block  = strb_n_f && (m_data || m_ext);
  assign next_out_oe = oen_samp && !sel_block && !strb_block;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      oen_samp           <= 1'b0;
      pass_samp          <= 1'b0;
      addr_hold          <= smp_pkg::DATA_RST;
      output_data_bus    <= smp_pkg::DATA_RST;
      output_data_bus_oe <= 1'b0;
    end else begin
      oen_samp           <= oen_f;
      pass_samp          <= pass_f;
      addr_hold          <= addr_f;
      output_data_bus    <= pass_samp ? addr_hold : mem_rd;
      output_data_bus_oe <= next_out_oe;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  counter_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!frm_n_f && !m_shift) |=> (frame_count == smp_pkg::COUNT_RST))
    else $error("Frame pulse did not clear counter");

  enable_off_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !oen_samp |=> !output_data_bus_oe)
    else $error("Output bus driven with enable low");

  enable_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ($rose(oen_f) && !sel_block && !strb_block) ##1 (!sel_block && !strb_block)
      |=> output_data_bus_oe)
    else $error("Output enable not applied on next edge");

  passthru_src_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pass_samp ##1 pass_samp |-> (output_data_bus == $past(addr_hold)))
    else $error("Pass-through source wrong");

  select_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (sel_n_f && (m_data || m_ext || m_cnt)) |=> !output_data_bus_oe)
    else $error("Output bus driven while deselected");

  strobe_block_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (strb_n_f && (m_data || m_ext)) |=> !output_data_bus_oe)
    else $error("Output bus driven with strobe high");

  ack_release_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((state == smp_pkg::SMP_ST_ACK) && end_cycle) |=> !transfer_ack_n_oe)
    else $error("Acknowledge not released");

  write_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    up_we |=> transfer_ack_n_oe)
    else $error("Write not acknowledged after latch");

  read_ack_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (transfer_ack_n_oe && rw_lat && m_conn && selected) |-> input_data_bus_oe)
    else $error("Read acknowledged before data driven");

  deselect_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((state == smp_pkg::SMP_ST_IDLE) && !selected) |=> (state == smp_pkg::SMP_ST_IDLE))
    else $error("Access started while deselected");

  conn_only_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    input_data_bus_oe |-> $past(m_conn))
    else $error("Input bus driven outside connect mode");

  stream_write_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((m_ext || m_cnt) && !rw_f) ##1 (m_ext || m_cnt) |-> st_we)
    else $error("Sampled write not carried out next edge");

endmodule // smp_switch_port

/* smp_host_model.sv */
`timescale 1ns/1ps

module smp_host_model (
  // Clock
  input  wire logic        clk_sys,
  // Device answers
  input  wire logic        transfer_ack_n,
  input  wire logic [15:0] dev_data,
  input  wire logic        dev_data_oe,
  // Microport pins
  output logic             device_select_n,
  output logic             data_strobe_n,
  output logic             read_write,
  output logic [15:0]      data_in
);
  // ***************************************************************
  // Bus level
  // ***************************************************************
  logic [15:0] host_data;
  logic        host_drive;

  // A released bus shows the inverse, never a stale copy
  assign data_in = dev_data_oe ? dev_data : (host_drive ? host_data : ~host_data);

  initial begin
    device_select_n = 1'b1;
    data_strobe_n   = 1'b1;
    read_write      = 1'b1;
    host_data       = 16'h0000;
    host_drive      = 1'b0;
  end

  // ***************************************************************
  // One strobed transfer
  // ***************************************************************
  task automatic xfer(input bit sel, input bit wr, input logic [15:0] wdata,
                      output logic [15:0] rdata, output bit acked);
    int i;
    acked = 1'b0;
    rdata = 16'h0000;
    @(negedge clk_sys);
    device_select_n = ~sel;
    read_write      = ~wr;
    host_data       = wdata;
    host_drive      = wr;
    data_strobe_n   = 1'b0;
    for (i = 0; i < 20 && !acked; i++) begin
      @(posedge clk_sys);
      acked = (transfer_ack_n === 1'b0);
      rdata = data_in;
    end
    @(negedge clk_sys);
    data_strobe_n   = 1'b1;
    device_select_n = 1'b1;
    host_drive      = 1'b0;
    read_write      = 1'b1;
    // Wait for the release before any new strobe
    for (i = 0; i < 20 && transfer_ack_n !== 1'b1; i++) @(posedge clk_sys);
    if (transfer_ack_n !== 1'b1) acked = 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule // smp_host_model

/* smp_switch_port_tb.sv */
`timescale 1ns/1ps

module smp_switch_port_tb;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic        clk_sys, rst_b, mode_select_x, mode_select_y, mode_select_z;
  logic        device_select_n, data_strobe_n, read_write;
  logic        transfer_ack_n_out, transfer_ack_n_oe, transfer_ack_n;
  logic [15:0] input_data_bus_in, input_data_bus_out, address_bus, output_data_bus;
  logic        input_data_bus_oe, output_bus_enable, address_passthrough_select;
  logic        output_data_bus_oe, frame_pulse_n;
  logic [10:0] frame_count, seen_count;
  logic [15:0] rd;
  bit          ok;
  int          n_mismatch, num_checks;

  typedef struct { bit wr; logic [15:0] addr; logic [15:0] data; } smp_tb_row_s;
  // Writes then reads; the last read aliases through address bit 11
  smp_tb_row_s rows [6] = '{'{1, 16'h0000, 16'ha5a5}, '{1, 16'h07ff, 16'h5a5a},
    '{1, 16'h0123, 16'hffff}, '{0, 16'h0000, 16'ha5a5}, '{0, 16'h07ff, 16'h5a5a},
    '{0, 16'h0923, 16'hffff}};
  logic [2:0] modes [5] = '{3'b000, 3'b001, 3'b010, 3'b011, 3'b100};
  logic       idle_oe [5] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

  // Open-drain acknowledge with pull-up
  assign transfer_ack_n = transfer_ack_n_oe ? transfer_ack_n_out : 1'b1;

  smp_switch_port smp_switch_port_inst (
    .clk_sys(clk_sys), .rst_b(rst_b), .mode_select_x(mode_select_x),
    .mode_select_y(mode_select_y), .mode_select_z(mode_select_z),
    .device_select_n(device_select_n), .data_strobe_n(data_strobe_n),
    .read_write(read_write), .transfer_ack_n_out(transfer_ack_n_out),
    .transfer_ack_n_oe(transfer_ack_n_oe), .input_data_bus_in(input_data_bus_in),
    .input_data_bus_out(input_data_bus_out), .input_data_bus_oe(input_data_bus_oe),
    .address_bus(address_bus), .output_bus_enable(output_bus_enable),
    .address_passthrough_select(address_passthrough_select),
    .output_data_bus(output_data_bus), .output_data_bus_oe(output_data_bus_oe),
    .frame_pulse_n(frame_pulse_n), .frame_count(frame_count));

  smp_host_model smp_host_model_inst (
    .clk_sys(clk_sys), .transfer_ack_n(transfer_ack_n), .dev_data(input_data_bus_out),
    .dev_data_oe(input_data_bus_oe), .device_select_n(device_select_n),
    .data_strobe_n(data_strobe_n), .read_write(read_write), .data_in(input_data_bus_in));

  always #5 clk_sys = ~clk_sys;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Pins pass a synchroniser, so settle well past its depth
  task automatic set_mode(input logic [2:0] m);
    {mode_select_z, mode_select_y, mode_select_x} = m;
    repeat (8) @(negedge clk_sys);
  endtask

  // ***************************************************************
  // Sequence
  // ***************************************************************
  initial begin
    clk_sys = 1'b0; rst_b = 1'b0; frame_pulse_n = 1'b1; address_bus = 16'h0000;
    {mode_select_z, mode_select_y, mode_select_x} = 3'b000;
    output_bus_enable = 1'b1; address_passthrough_select = 1'b0;
    n_mismatch = 0; num_checks = 0;
    repeat (2) @(negedge clk_sys);
    check("reset ack oe", 16'h0000, {15'h0000, transfer_ack_n_oe});
    check("reset out oe", 16'h0000, {15'h0000, output_data_bus_oe});
    check("reset count", 16'h0000, {5'h00, frame_count});
    rst_b = 1'b1;
    repeat (2) @(negedge clk_sys);
    // Release of reset must not look like a strobe and start a transfer
    check("post-reset ack oe", 16'h0000, {15'h0000, transfer_ack_n_oe});
    repeat (3) @(negedge clk_sys);
    foreach (rows[i]) begin
      address_bus = rows[i].addr;
      smp_host_model_inst.xfer(1'b1, rows[i].wr, rows[i].data, rd, ok);
      check("ack", 16'h0001, {15'h0000, ok});
      if (!ok) stop_test();
      if (!rows[i].wr) check("read data", rows[i].data, rd);
    end
    // Strobe while deselected must leave memory alone
    address_bus = 16'h0000;
    smp_host_model_inst.xfer(1'b0, 1'b1, 16'h1111, rd, ok);
    check("deselected ack", 16'h0000, {15'h0000, ok});
    smp_host_model_inst.xfer(1'b1, 1'b0, 16'h0000, rd, ok);
    check("after deselect", 16'ha5a5, rd);
    // Output source selection
    address_bus = 16'h1234; address_passthrough_select = 1'b1;
    repeat (8) @(negedge clk_sys);
    check("pass-through", 16'h1234, output_data_bus);
    address_bus = 16'h07ff; address_passthrough_select = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("memory out", 16'h5a5a, output_data_bus);
    // Frame pulse clears, release resumes counting one per edge
    frame_pulse_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    check("count cleared", 16'h0000, {5'h00, frame_count});
    frame_pulse_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    seen_count = frame_count;
    @(negedge clk_sys);
    check("count step", {5'h00, seen_count + 11'h001}, {5'h00, frame_count});
    // Idle select and strobe gate the output bus by mode
    foreach (modes[i]) begin
      set_mode(modes[i]);
      check("idle out oe", {15'h0000, idle_oe[i]}, {15'h0000, output_data_bus_oe});
      output_bus_enable = 1'b0;
      repeat (8) @(negedge clk_sys);
      check("disabled out oe", 16'h0000, {15'h0000, output_data_bus_oe});
      output_bus_enable = 1'b1;
    end
    // Strobe in counter mode gets no handshake
    set_mode(3'b011);
    smp_host_model_inst.xfer(1'b1, 1'b0, 16'h0000, rd, ok);
    check("counter ack", 16'h0000, {15'h0000, ok});
    stop_test();
  end
endmodule // smp_switch_port_tb
